/* common/nsal_pkg.sv */
// constants and carrier types for the nvm status, address and region-protect block
// ----------------------------------------------------------------------------
// Function
// - protected-region program sets violation flag, W1C
// - bad command or key sets flag, W1C
// - word loaded sets page-buffer-loaded flag
// - loaded flag cleared by page write/clear/W1C
// - low power entered by command or sleep
// - low power left by access, command, wake
// - low power status bit read-only, one active
// - target location drives halfword address on execute
// - page buffer write updates target location
// - protect bits read-only, changed by commands
// - configuration erase leaves all regions unprotected
// - protect bit zero means region protected
// ----------------------------------------------------------------------------
`default_nettype none
package nsal_pkg;
  // register byte offsets
  localparam logic [7:0] NSAL_STATUS_OFS = 8'h18;
  localparam logic [7:0] NSAL_TARGET_OFS = 8'h1C;
  localparam logic [7:0] NSAL_PROTECT_OFS = 8'h20;
  localparam logic [7:0] NSAL_CTRL_OFS = 8'h24;
  localparam logic [7:0] NSAL_IRQ_FLAG_OFS = 8'h28;
  localparam logic [7:0] NSAL_IRQ_CLR_OFS = 8'h2C;
  localparam logic [7:0] NSAL_IRQ_EN_OFS = 8'h30;
  // status and control field positions
  localparam int NSAL_LOWPWR_BIT = 0;
  localparam int NSAL_LOADED_BIT = 1;
  localparam int NSAL_BADCMD_BIT = 2;
  localparam int NSAL_VIOL_BIT = 3;
  localparam int NSAL_POLICY_BIT = 0;
  // widths
  localparam int NSAL_ADDR_W = 22;
  localparam int NSAL_HADDR_W = 16;
  localparam int NSAL_REGIONS = 16;
  localparam int NSAL_EVENTS = 3;
  // reset values
  localparam logic [21:0] NSAL_TARGET_RST = 22'h000000;
  localparam logic [15:0] NSAL_PROTECT_ERASED = 16'hFFFF;
  // command sequencer states
  typedef enum logic [1:0] {
    NSAL_IDLE = 2'b00,
    NSAL_EXEC = 2'b01,
    NSAL_DONE = 2'b11
  } nsal_state_t;
  // command events from the command decoder
  typedef struct packed {
    logic execute;
    logic bad;
    logic page_write;
    logic page_clear;
    logic set_low;
    logic clear_low;
    logic protect;
    logic unprotect;
    logic erase_config;
    logic [3:0] region;
  } nsal_cmd_t;
  // page buffer write strobe with its location
  typedef struct packed {
    logic load;
    logic [21:0] addr;
  } nsal_load_t;
endpackage
`default_nettype wire

/* verilog/nsal_flag.sv */
// one sticky write-one-to-clear flag where a set wins over a clear
`timescale 1ns/1ns
`default_nettype none
module nsal_flag
  import nsal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  logic next_flag;
  // set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    next_flag = set | (flag & ~clr);
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
    end
  end
endmodule
`default_nettype wire

/* verilog/nsal_top.sv */
// status, target location and region protect registers of the nvm controller
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module nsal_top
  import nsal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire nsal_cmd_t cmd,
  input wire nsal_load_t load,
  input wire logic prog_protected,
  input wire logic mem_access,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  output logic [15:0] nvm_haddr,
  output logic nvm_exec,
  output logic low_power_state,
  output logic [15:0] region_protect,
  output logic irq
);
  // register map, one aligned word each:
  //   status     [3] violation, [2] bad command, [1] loaded (write one to clear)
  //              [0] low power mode (read-only)
  //   target     [21:0] location; bits [15:0] go to the memory as the halfword address on execute
  //   protect    [15:0] one bit per region, zero means protected (read-only)
  //   control    [0] sleep power policy
  //   irq flag   [2] violation, [1] bad command, [0] loaded (read-only)
  //   irq clear  write one to drop an irq flag; reads zero
  //   irq enable same layout as the irq flags
  //   any other offset answers with an error
  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    nsal_state_t st;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic miss;
    logic [21:0] target;
    logic [15:0] protect;
    logic lowpwr;
    logic policy;
    logic [15:0] haddr;
    logic exec;
    logic [2:0] ev_en;
    logic irq;
  } nsal_regs_t;
  nsal_regs_t r;
  nsal_regs_t next_r;
  // bus side
  logic wr_acc;
  logic setup;
  logic sel_status;
  logic sel_target;
  logic sel_protect;
  logic sel_ctrl;
  logic sel_irq_flag;
  logic sel_irq_clr;
  logic sel_irq_en;
  logic wr_status;
  logic wr_target;
  logic wr_ctrl;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic [31:0] rd_word;
  // low power requests
  logic wake;
  logic sleep_in;
  // flags
  logic [3:0] flag_q;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [2:0] ev_flag;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic hit;

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  // setup cycle: read data and the error answer are prepared here
  assign setup = psel & ~penable;
  // the write lands on the access edge only, once ready is already up
  assign wr_acc = psel & penable & pwrite & r.ready;
  // full byte compares, so a stray offset never aliases onto a register
  assign sel_status = (paddr == NSAL_STATUS_OFS);
  assign sel_target = (paddr == NSAL_TARGET_OFS);
  assign sel_protect = (paddr == NSAL_PROTECT_OFS);
  assign sel_ctrl = (paddr == NSAL_CTRL_OFS);
  assign sel_irq_flag = (paddr == NSAL_IRQ_FLAG_OFS);
  assign sel_irq_clr = (paddr == NSAL_IRQ_CLR_OFS);
  assign sel_irq_en = (paddr == NSAL_IRQ_EN_OFS);
  // anything outside the map answers with an error and has no side effect
  assign hit = sel_status | sel_target | sel_protect | sel_ctrl |
    sel_irq_flag | sel_irq_clr | sel_irq_en;
  // write strobes; the protect and irq flag words have none on purpose
  assign wr_status = wr_acc & sel_status;
  assign wr_target = wr_acc & sel_target;
  assign wr_ctrl = wr_acc & sel_ctrl;
  assign wr_irq_clr = wr_acc & sel_irq_clr;
  assign wr_irq_en = wr_acc & sel_irq_en;

  // ----------------------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------------------
  always_comb
  begin
    // the low power bit is never sticky, so its set and clear stay zero
    flag_set = 4'h0;
    flag_clr = 4'h0;
    flag_set[NSAL_VIOL_BIT] = prog_protected;
    flag_set[NSAL_BADCMD_BIT] = cmd.bad;
    flag_set[NSAL_LOADED_BIT] = load.load;
    if (wr_status)
    begin
      flag_clr[NSAL_VIOL_BIT:NSAL_LOADED_BIT] = pwdata[NSAL_VIOL_BIT:NSAL_LOADED_BIT];
    end
    // page write or buffer clear ends loaded state
    flag_clr[NSAL_LOADED_BIT] = flag_clr[NSAL_LOADED_BIT] | cmd.page_write | cmd.page_clear;
  end

  // interrupt events: violation, bad command, loaded
  assign ev_set = {flag_set[NSAL_VIOL_BIT], flag_set[NSAL_BADCMD_BIT], flag_set[NSAL_LOADED_BIT]};
  // a clear and a new event in one cycle leave the flag set
  assign ev_clr = wr_irq_clr ? pwdata[NSAL_EVENTS-1:0] : 3'h0;

  generate
    for (genvar i = NSAL_LOADED_BIT; i <= NSAL_VIOL_BIT; i++)
    begin : g_status
      nsal_flag u_flag (
        .clk(clk),
        .rst(rst),
        .set(flag_set[i]),
        .clr(flag_clr[i]),
        .flag(flag_q[i])
      );
    end
    for (genvar j = 0; j < NSAL_EVENTS; j++)
    begin : g_irq
      nsal_flag u_ev (
        .clk(clk),
        .rst(rst),
        .set(ev_set[j]),
        .clr(ev_clr[j]),
        .flag(ev_flag[j])
      );
    end
  endgenerate
  // bit zero is the live mode, not a sticky flag
  assign flag_q[NSAL_LOWPWR_BIT] = r.lowpwr;

  // ----------------------------------------------------------------------------
  // low power requests
  // ----------------------------------------------------------------------------
  // sleep entry and exit only count while the policy bit asks for them;
  // a bus access to the memory wakes it whatever the policy, unless a sleep entry or set command comes in the same cycle
  assign wake = mem_access | (sleep_exit & r.policy);
  assign sleep_in = sleep_enter & r.policy;

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  // unused bits, the write-only word and holes in the map all read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      NSAL_STATUS_OFS:
      begin
        rd_word[NSAL_VIOL_BIT:NSAL_LOWPWR_BIT] = flag_q;
      end
      NSAL_TARGET_OFS:
      begin
        rd_word[NSAL_ADDR_W-1:0] = r.target;
      end
      NSAL_PROTECT_OFS:
      begin
        rd_word[NSAL_REGIONS-1:0] = r.protect;
      end
      NSAL_CTRL_OFS:
      begin
        rd_word[NSAL_POLICY_BIT] = r.policy;
      end
      NSAL_IRQ_FLAG_OFS:
      begin
        rd_word[NSAL_EVENTS-1:0] = ev_flag;
      end
      NSAL_IRQ_EN_OFS:
      begin
        rd_word[NSAL_EVENTS-1:0] = r.ev_en;
      end
      // the irq clear word is write-only and reads as zero
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.exec = 1'b0;
    // one wait state: ready rises in the second access cycle
    next_r.ready = psel & penable & ~r.ready;
    // the error answer rises and falls with ready, from a flop of its own
    next_r.err = psel & penable & ~r.ready & r.miss;
    // read data and the miss are taken in the setup cycle and held to the answer
    if (setup)
    begin
      next_r.rdata = rd_word;
      next_r.miss = ~hit;
    end
    // software writes; leave low power and protect bits unwritable
    if (wr_target)
    begin
      next_r.target = pwdata[NSAL_ADDR_W-1:0];
    end
    if (wr_ctrl)
    begin
      next_r.policy = pwdata[NSAL_POLICY_BIT];
    end
    if (wr_irq_en)
    begin
      next_r.ev_en = pwdata[NSAL_EVENTS-1:0];
    end
    // placed after the bus write, so a load in the same cycle wins
    // page buffer write tracks location, after any software write
    if (load.load)
    begin
      next_r.target = load.addr;
    end
    // unprotect comes after protect, so it wins on the same region;
    // a configuration erase below overrides both
    // protect bits move only by command
    if (cmd.protect)
    begin
      next_r.protect[cmd.region] = 1'b0;
    end
    if (cmd.unprotect)
    begin
      next_r.protect[cmd.region] = 1'b1;
    end
    if (cmd.erase_config)
    begin
      next_r.protect = NSAL_PROTECT_ERASED;
    end
    // later assignments win: wake, then sleep entry, then set, then clear,
    // so an explicit command keeps the last word over system events
    // wake on access or on sleep exit
    if (wake)
    begin
      next_r.lowpwr = 1'b0;
    end
    if (sleep_in)
    begin
      next_r.lowpwr = 1'b1;
    end
    // set command enters, clear command leaves
    if (cmd.set_low)
    begin
      next_r.lowpwr = 1'b1;
    end
    if (cmd.clear_low)
    begin
      next_r.lowpwr = 1'b0;
    end
    // execute key drives halfword address for one pulse
    case (r.st)
      NSAL_IDLE:
      begin
        if (cmd.execute)
        begin
          next_r.haddr = r.target[NSAL_HADDR_W-1:0];
          next_r.exec = 1'b1;
          next_r.st = NSAL_EXEC;
        end
      end
      // the pulse cycle and the one after it ignore the key: a key repeated inside them is dropped,
      // so the memory never sees a second start while it takes the address
      NSAL_EXEC:
      begin
        next_r.st = NSAL_DONE;
      end
      NSAL_DONE:
      begin
        next_r.st = NSAL_IDLE;
      end
      default: next_r.st = NSAL_IDLE;
    endcase
    // interrupt level from enabled events; registered, so it trails the flag
    // by one cycle and never glitches while software changes the enables
    next_r.irq = |(ev_flag & r.ev_en);
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // everything idle, all regions unprotected, low power off
      r <= '0;
      r.target <= NSAL_TARGET_RST;
      r.protect <= NSAL_PROTECT_ERASED;
      r.st <= NSAL_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from flops; nothing combinational reaches a pin,
  // so the memory side and the bus both see clean edges
  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.err;
  assign nvm_haddr = r.haddr;
  assign nvm_exec = r.exec;
  assign low_power_state = r.lowpwr;
  assign region_protect = r.protect;
  assign irq = r.irq;
endmodule
`default_nettype wire

/* dv/nsal_top_properties.sv */
// port checks for the nvm status, address and protect block
`timescale 1ns/1ns
`default_nettype none
module nsal_top_properties
  import nsal_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire nsal_cmd_t cmd,
  input wire logic mem_access,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic nvm_exec,
  input wire logic [15:0] nvm_haddr,
  input wire logic low_power_state,
  input wire logic [15:0] region_protect
);
  // one domain; every check idles in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // clear command outranks set, set outranks every wake
  chk_lp_enter: assert property (cmd.set_low && !cmd.clear_low |=> low_power_state)
    else $error("low power not entered");
  chk_lp_leave: assert property (cmd.clear_low |=> !low_power_state)
    else $error("low power kept");
  chk_lp_wake: assert property (mem_access && !sleep_enter && !cmd.set_low |=> !low_power_state)
    else $error("no wake on access");
  chk_lp_hold: assert property (!(mem_access || sleep_enter || sleep_exit || cmd.set_low || cmd.clear_low)
    |=> $stable(low_power_state)) else $error("low power moved");
  chk_prot_erase: assert property (cmd.erase_config |=> region_protect == 16'hFFFF)
    else $error("erase left a region protected");
  chk_prot_hold: assert property (!(cmd.protect || cmd.unprotect || cmd.erase_config)
    |=> $stable(region_protect)) else $error("protect bits moved");
  chk_prot_set: assert property (cmd.protect && !cmd.unprotect && !cmd.erase_config
    |=> !region_protect[$past(cmd.region)]) else $error("protected region reads one");
  chk_exec_cause: assert property (nvm_exec |-> $past(cmd.execute))
    else $error("exec without command");
  chk_haddr_hold: assert property (!cmd.execute && !$past(cmd.execute) |=> $stable(nvm_haddr))
    else $error("halfword address moved");
endmodule
bind nsal_top nsal_top_properties u_props (.clk, .rst, .cmd, .mem_access, .sleep_enter, .sleep_exit,
  .nvm_exec, .nvm_haddr, .low_power_state, .region_protect);
`default_nettype wire

/* dv/tb_nvm_status_address_lock_regs.sv */
// random and corner tests of the nvm status, address and protect block
`timescale 1ns/1ns
`default_nettype none
module tb_nvm_status_address_lock_regs
  import nsal_pkg::*;
  ;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic err, pready, pslverr, nvm_exec, low_power_state, irq;
  logic [3:0] g;
  logic [4:0] ev = 5'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [21:0] la = 22'h0, tgt;
  logic [15:0] nvm_haddr, region_protect, prot = 16'hFFFF;
  logic [12:0] tc [6] = '{13'h100, 13'h0, 13'h0, 13'h0, 13'h100, 13'h80};
  logic [4:0] te [6] = '{5'h0, 5'h4, 5'h2, 5'h1, 5'h0, 5'h0};
  nsal_cmd_t cmd = '0;
  int bad_count = 0, num_checks = 0, i;
  // 50 MHz clock
  always #10 clk = ~clk;
  // load strobe and side events share one pulse vector
  nsal_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd,
    .load({ev[4], la}), .prog_protected(ev[3]), .mem_access(ev[2]), .sleep_enter(ev[1]), .sleep_exit(ev[0]),
    .nvm_haddr, .nvm_exec, .low_power_state, .region_protect, .irq);
  task automatic print_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer plus an idle cycle, so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1 && ++k < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      bad_count++;
      print_verdict;
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  // one-cycle command and event pulses; exec sampled mid-cycle
  task automatic fire(input logic [12:0] c, input logic [4:0] e);
    cmd <= nsal_cmd_t'(c);
    ev <= e;
    @(posedge clk);
    cmd <= '0;
    ev <= 5'h0;
    @(negedge clk);
    chk(nvm_exec, c[12]);
    @(posedge clk);
  endtask
  // expected protect word after a single region command
  function automatic logic [15:0] lk(input logic [15:0] p, input logic [3:0] n, input logic u);
    lk = p;
    lk[n] = u;
  endfunction
  // main sequence
  initial
  begin
    i = $urandom(84929);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(NSAL_STATUS_OFS, 32'h0);
    rd(NSAL_TARGET_OFS, 32'h0);
    rd(NSAL_PROTECT_OFS, 32'hFFFF);
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 32'h1);
    // sticky flags: load, bad command, violation; irq masked, then raised and cleared
    for (i = 1; i < 4; i++)
    begin
      la <= 22'($urandom);
      fire(i == 2 ? 13'h800 : 13'h0, {i == 1, i == 3, 3'h0});
      wr(NSAL_STATUS_OFS, 32'h0);
      rd(NSAL_STATUS_OFS, 32'h1 << i);
      chk(irq, 32'h0);
      wr(NSAL_IRQ_EN_OFS, 32'h1 << (i - 1));
      rd(NSAL_IRQ_FLAG_OFS, 32'h1 << (i - 1));
      chk(irq, 32'h1);
      wr(NSAL_IRQ_CLR_OFS, 32'h1 << (i - 1));
      rd(NSAL_IRQ_FLAG_OFS, 32'h0);
      chk(irq, 32'h0);
      wr(NSAL_STATUS_OFS, 32'h1 << i);
      rd(NSAL_STATUS_OFS, 32'h0);
      wr(NSAL_IRQ_EN_OFS, 32'h0);
    end
    // page write and page clear both drop the loaded flag
    for (i = 9; i < 11; i++)
    begin
      fire(13'h0, 5'h10);
      fire(13'h1 << i, 5'h0);
      rd(NSAL_STATUS_OFS, 32'h0);
    end
    // target by page load at the top corner, then by a random software write
    for (i = 0; i < 2; i++)
    begin
      tgt = i ? 22'($urandom) : 22'h3FFFFF;
      la <= tgt;
      if (i)
        wr(NSAL_TARGET_OFS, {10'h3FF, tgt});
      else
        fire(13'h0, 5'h10);
      fire(13'h1000, 5'h0);
      rd(NSAL_TARGET_OFS, {10'h0, tgt});
      chk(nvm_haddr, tgt[15:0]);
    end
    wr(NSAL_STATUS_OFS, 32'h2);
    // enter and leave low power by every path; bit zero ignores writes
    wr(NSAL_CTRL_OFS, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      fire(tc[i], te[i]);
      chk(low_power_state, i % 2 == 0);
      wr(NSAL_STATUS_OFS, 32'h1);
      rd(NSAL_STATUS_OFS, 32'(i % 2 == 0));
    end
    wr(NSAL_CTRL_OFS, 32'h0);
    fire(13'h0, 5'h2);
    chk(low_power_state, 32'h0);
    // region protect: end regions then random, bus writes ignored
    for (i = 0; i < 6; i++)
    begin
      if (i % 2 == 0)
        g = i == 0 ? 4'h0 : i == 2 ? 4'hF : 4'($urandom);
      fire((i % 2 ? 13'h20 : 13'h40) | 13'(g), 5'h0);
      prot = lk(prot, g, i[0]);
      wr(NSAL_PROTECT_OFS, 32'h0);
      rd(NSAL_PROTECT_OFS, {16'h0, prot});
      chk(region_protect, prot);
    end
    fire(13'h43, 5'h0);
    fire(13'h4C, 5'h0);
    fire(13'h10, 5'h0);
    rd(NSAL_PROTECT_OFS, 32'hFFFF);
    print_verdict;
  end
endmodule
`default_nettype wire
